// file: core/mps_regs.vh
`ifndef MPS_REGS_VH
`define MPS_REGS_VH
// ****************************************************************
// register word offsets (byte addresses)
// ****************************************************************
`define MPS_A_CTRL      8'h00
`define MPS_A_WARN_LVL  8'h04
`define MPS_A_WARN_TIME 8'h08
`define MPS_A_TRIP_LVL  8'h0c
`define MPS_A_TRIP_TIME 8'h10
`define MPS_A_STALL_LVL 8'h14
`define MPS_A_RATED     8'h18
`define MPS_A_OUT_SEL   8'h1c
`define MPS_A_IN_SEL0   8'h20
`define MPS_A_CMD       8'h34
`define MPS_A_STATUS    8'h38
// ****************************************************************
// field positions
// ****************************************************************
`define MPS_B_TRIP_EN   0
`define MPS_B_PHASE_EN  1
`define MPS_B_RESTART   2
`define MPS_B_STALL_LO  4
`define MPS_B_OUT2_LO   8
`define MPS_B_FLT_RST   0
// ****************************************************************
// reset values
// ****************************************************************
`define MPS_R_TRIP_EN   1'h1
`define MPS_R_PHASE_EN  1'h0
`define MPS_R_RESTART   1'h0
`define MPS_R_STALL_SEL 3'h0
`define MPS_R_WARN_LVL  8'h96
`define MPS_R_WARN_TIME 10'h064
`define MPS_R_TRIP_LVL  8'hb4
`define MPS_R_TRIP_TIME 10'h258
`define MPS_R_STALL_LVL 8'h96
`define MPS_R_OUT_SEL   5'h11
`define MPS_R_IN1_SEL   5'h00
`define MPS_R_IN2_SEL   5'h01
`define MPS_R_IN3_SEL   5'h02
`define MPS_R_IN4_SEL   5'h03
`define MPS_R_IN5_SEL   5'h04
// ****************************************************************
// function codes and timing
// ****************************************************************
`define MPS_F_OL_WARN   5'h05
`define MPS_F_STALL     5'h07
`define MPS_F_EXT_A     5'h12
`define MPS_F_EXT_B     5'h13
`define MPS_PCT_SCALE   8'h64
`define MPS_RESTART_LIM 10'h12c
`define MPS_TICK_MS     100
`define MPS_CLK_KHZ     40000
`endif

// file: core/mps_supervisor.v
// Functional notes
// - output selector code 5 drives the overload warning; warn time 0.0-30.0 s
// - warning level is percent of rated current, 30-150, default 150
// - overload trip enabled when its bit is 1, default enabled
// - block output when current above trip level for trip time
// - overload trip with auto restart and trip time over 30 s clears restart count
// - accelerating with bit0 set: decelerate while current above stall level
// - constant speed with bit1 set: decelerate while current above stall level
// - decelerating with bit2 set: hold deceleration while dc bus at limit
// - stall level is percent of rated current, 30-200, default 150
// - stall select is three bits, default 000, acc/const/dec from low bit
// - output selector code 7 shows stall state regardless of enables
// - stall action at steady speed ramps with configured acc and dec times
// - open-phase protection enabled blocks output when any phase opens
// - input selector code 18 is contact A trip, code 19 contact B trip
// - contact A is normally open; closing to common blocks output
// - contact B is normally closed; opening from common blocks output
// - contact B trip survives a function change; contact must close first
// - inputs four and five exist only on the extended variant
`timescale 1ns/100ps
`include "mps_regs.vh"
module mps_supervisor #(
    parameter EXT_IO      = 1,
    parameter CUR_W       = 16,
    parameter RATED_RST   = 16'h0100,
    parameter TICK_CYCLES = `MPS_TICK_MS * `MPS_CLK_KHZ
) (
    // clock, reset, enable
    input  wire             i_core_clk,
    input  wire             i_rst_n,
    input  wire             i_ce,
    // register port
    input  wire [7:0]       i_addr,
    input  wire [31:0]      i_wdata,
    input  wire             i_wr,
    input  wire             i_rd,
    output reg  [31:0]      o_rdata,
    // drive state and measurements, same clock
    input  wire [CUR_W-1:0] i_out_current,
    input  wire             i_accel,
    input  wire             i_steady,
    input  wire             i_decel,
    input  wire             i_dc_bus_limit,
    // pins, asynchronous
    input  wire [2:0]       i_phase_open,
    input  wire [4:0]       i_multi_in_closed,
    // drive commands
    output reg              o_out_block,
    output reg              o_stall_decel,
    output reg              o_decel_hold,
    output reg              o_use_cfg_ramp,
    output reg              o_restart_cnt_clr,
    // multi-function outputs
    output reg              o_relay_contact_set,
    output reg              o_output2
);
// ****************************************************************
// configuration registers
// ****************************************************************
reg              trip_en_ff;
reg              phase_en_ff;
reg              restart_en_ff;
reg  [2:0]       stall_sel_ff;
reg  [7:0]       warn_lvl_ff;
reg  [9:0]       warn_time_ff;
reg  [7:0]       trip_lvl_ff;
reg  [9:0]       trip_time_ff;
reg  [7:0]       stall_lvl_ff;
reg  [15:0]      rated_ff;
reg  [4:0]       relay_sel_ff;
reg  [4:0]       out2_sel_ff;
reg  [4:0]       in_sel_ff [0:4];
wire             wr_cmd;
wire             fault_rst;
integer          k;

assign wr_cmd    = i_ce & i_wr;
assign fault_rst = wr_cmd & (i_addr == `MPS_A_CMD) & i_wdata[`MPS_B_FLT_RST];

// register writes; inputs four and five are not writable on the basic variant
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        trip_en_ff    <= `MPS_R_TRIP_EN;
        phase_en_ff   <= `MPS_R_PHASE_EN;
        restart_en_ff <= `MPS_R_RESTART;
        stall_sel_ff  <= `MPS_R_STALL_SEL;
        warn_lvl_ff   <= `MPS_R_WARN_LVL;
        warn_time_ff  <= `MPS_R_WARN_TIME;
        trip_lvl_ff   <= `MPS_R_TRIP_LVL;
        trip_time_ff  <= `MPS_R_TRIP_TIME;
        stall_lvl_ff  <= `MPS_R_STALL_LVL;
        rated_ff      <= RATED_RST;
        relay_sel_ff  <= `MPS_R_OUT_SEL;
        out2_sel_ff   <= `MPS_R_OUT_SEL;
        in_sel_ff[0]  <= `MPS_R_IN1_SEL;
        in_sel_ff[1]  <= `MPS_R_IN2_SEL;
        in_sel_ff[2]  <= `MPS_R_IN3_SEL;
        in_sel_ff[3]  <= `MPS_R_IN4_SEL;
        in_sel_ff[4]  <= `MPS_R_IN5_SEL;
    end else if (wr_cmd) begin
        case (i_addr)
            `MPS_A_CTRL: begin
                trip_en_ff    <= i_wdata[`MPS_B_TRIP_EN];
                phase_en_ff   <= i_wdata[`MPS_B_PHASE_EN];
                restart_en_ff <= i_wdata[`MPS_B_RESTART];
                stall_sel_ff  <= i_wdata[`MPS_B_STALL_LO +: 3];
            end
            `MPS_A_WARN_LVL:  warn_lvl_ff  <= i_wdata[7:0];
            `MPS_A_WARN_TIME: warn_time_ff <= i_wdata[9:0];
            `MPS_A_TRIP_LVL:  trip_lvl_ff  <= i_wdata[7:0];
            `MPS_A_TRIP_TIME: trip_time_ff <= i_wdata[9:0];
            `MPS_A_STALL_LVL: stall_lvl_ff <= i_wdata[7:0];
            `MPS_A_RATED:     rated_ff     <= i_wdata[15:0];
            `MPS_A_OUT_SEL: begin
                relay_sel_ff <= i_wdata[4:0];
                out2_sel_ff  <= i_wdata[`MPS_B_OUT2_LO +: 5];
            end
            default: begin
                for (k = 0; k < 5; k = k + 1) begin
                    if (i_addr == `MPS_A_IN_SEL0 + 8'h04 * k[7:0]
                        && (k < 3 || EXT_IO != 0))
                        in_sel_ff[k] <= i_wdata[4:0];
                end
            end
        endcase
    end
end

// ****************************************************************
// pin synchronisers
// ****************************************************************
reg  [2:0]       phase_s1_ff;
reg  [2:0]       phase_s2_ff;
reg  [4:0]       min_s1_ff;
reg  [4:0]       min_s2_ff;
wire [4:0]       in_closed;

// two flip-flops per pin before any logic
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        phase_s1_ff <= 3'h0;
        phase_s2_ff <= 3'h0;
        min_s1_ff   <= 5'h1f;
        min_s2_ff   <= 5'h1f;
    end else if (i_ce) begin
        phase_s1_ff <= i_phase_open;
        phase_s2_ff <= phase_s1_ff;
        min_s1_ff   <= i_multi_in_closed;
        min_s2_ff   <= min_s1_ff;
    end
end

// basic variant: inputs four and five read as absent
assign in_closed = (EXT_IO != 0) ? min_s2_ff : {2'h0, min_s2_ff[2:0]};

// ****************************************************************
// current comparisons against percent of rated current
// ****************************************************************
wire [CUR_W+7:0] cur_x100;
wire [CUR_W+7:0] warn_thr;
wire [CUR_W+7:0] trip_thr;
wire [CUR_W+7:0] stall_thr;
reg              over_warn_ff;
reg              over_trip_ff;
reg              over_stall_ff;

assign cur_x100  = i_out_current * `MPS_PCT_SCALE;
assign warn_thr  = warn_lvl_ff * rated_ff;
assign trip_thr  = trip_lvl_ff * rated_ff;
assign stall_thr = stall_lvl_ff * rated_ff;

// registered compares keep the multipliers off the trip paths
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        over_warn_ff  <= 1'h0;
        over_trip_ff  <= 1'h0;
        over_stall_ff <= 1'h0;
    end else if (i_ce) begin
        over_warn_ff  <= cur_x100 > warn_thr;
        over_trip_ff  <= cur_x100 > trip_thr;
        over_stall_ff <= cur_x100 > stall_thr;
    end
end

// ****************************************************************
// tenth-second tick and duration timers
// ****************************************************************
reg  [31:0]      tick_cnt_ff;
wire             tick;
reg  [9:0]       warn_cnt_ff;
reg  [9:0]       trip_cnt_ff;
reg              warn_ff;
wire             trip_run;

assign tick     = (tick_cnt_ff == TICK_CYCLES - 1);
assign trip_run = trip_en_ff & over_trip_ff;

// free tick every 100 ms
always @(posedge i_core_clk) begin
    if (!i_rst_n)
        tick_cnt_ff <= 32'h0;
    else if (i_ce)
        tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
end

// time spent above the warn and trip levels, saturating, cleared when below
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        warn_cnt_ff <= 10'h0;
        trip_cnt_ff <= 10'h0;
        warn_ff     <= 1'h0;
    end else if (i_ce) begin
        if (!over_warn_ff)
            warn_cnt_ff <= 10'h0;
        else if (tick && warn_cnt_ff != 10'h3ff)
            warn_cnt_ff <= warn_cnt_ff + 10'h1;
        if (!trip_run)
            trip_cnt_ff <= 10'h0;
        else if (tick && trip_cnt_ff != 10'h3ff)
            trip_cnt_ff <= trip_cnt_ff + 10'h1;
        warn_ff <= over_warn_ff & (warn_cnt_ff >= warn_time_ff);
    end
end

// ****************************************************************
// trip latches
// ****************************************************************
reg              ol_trip_ff;
reg              phase_trip_ff;
reg              exta_trip_ff;
reg              extb_trip_ff;
reg  [4:0]       extb_src_ff;
reg  [4:0]       sel_a;
reg  [4:0]       sel_b;
wire             ol_set;
wire             phase_set;
wire             exta_set;
wire [4:0]       extb_open;
wire             extb_gone;
integer          j;

// which inputs carry each contact function
always @* begin
    sel_a = 5'h0;
    sel_b = 5'h0;
    for (j = 0; j < 5; j = j + 1) begin
        sel_a[j] = (in_sel_ff[j] == `MPS_F_EXT_A);
        sel_b[j] = (in_sel_ff[j] == `MPS_F_EXT_B);
    end
end

assign ol_set    = trip_run & (trip_cnt_ff >= trip_time_ff);
assign phase_set = phase_en_ff & (|phase_s2_ff);
assign exta_set  = |(sel_a & in_closed);
assign extb_open = sel_b & ~in_closed;
// the tripping inputs must be closed again, whatever their function now
assign extb_gone = ~|(extb_src_ff & ~in_closed);

// a set in the reset cycle wins; reset only clears a gone condition
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        ol_trip_ff    <= 1'h0;
        phase_trip_ff <= 1'h0;
        exta_trip_ff  <= 1'h0;
        extb_trip_ff  <= 1'h0;
        extb_src_ff   <= 5'h0;
    end else if (i_ce) begin
        if (ol_set)
            ol_trip_ff <= 1'h1;
        else if (fault_rst && !over_trip_ff)
            ol_trip_ff <= 1'h0;
        if (phase_set)
            phase_trip_ff <= 1'h1;
        else if (fault_rst)
            phase_trip_ff <= 1'h0;
        if (exta_set)
            exta_trip_ff <= 1'h1;
        else if (fault_rst)
            exta_trip_ff <= 1'h0;
        if (|extb_open) begin
            extb_trip_ff <= 1'h1;
            extb_src_ff  <= extb_src_ff | extb_open;
        end else if (fault_rst && extb_gone) begin
            extb_trip_ff <= 1'h0;
            extb_src_ff  <= 5'h0;
        end
    end
end

// ****************************************************************
// stall prevention and drive commands
// ****************************************************************
wire             stall_acc;
wire             stall_cv;
wire             hold_dec;
wire             stalled;
wire             any_trip;

assign stall_acc = stall_sel_ff[0] & i_accel & over_stall_ff;
assign stall_cv  = stall_sel_ff[1] & i_steady & over_stall_ff;
assign hold_dec  = stall_sel_ff[2] & i_decel & i_dc_bus_limit;
// stall state independent of the enable bits
assign stalled   = ((i_accel | i_steady) & over_stall_ff)
                 | (i_decel & i_dc_bus_limit);
assign any_trip  = ol_trip_ff | phase_trip_ff | exta_trip_ff | extb_trip_ff;

// registered commands towards the power stage
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        o_out_block       <= 1'h0;
        o_stall_decel     <= 1'h0;
        o_decel_hold      <= 1'h0;
        o_use_cfg_ramp    <= 1'h0;
        o_restart_cnt_clr <= 1'h0;
    end else if (i_ce) begin
        o_out_block    <= any_trip;
        o_stall_decel  <= (stall_acc | stall_cv) & ~any_trip;
        o_decel_hold   <= hold_dec & ~any_trip;
        o_use_cfg_ramp <= stall_cv;
        // pulse on the rising edge of the overload trip
        o_restart_cnt_clr <= ol_set & ~ol_trip_ff & restart_en_ff
                           & (trip_time_ff > `MPS_RESTART_LIM);
    end
end

// ****************************************************************
// multi-function outputs
// ****************************************************************
function mf_out;
    input [4:0] sel;
    input       warn;
    input       stall;
    begin
        mf_out = ((sel == `MPS_F_OL_WARN) & warn)
               | ((sel == `MPS_F_STALL) & stall);
    end
endfunction

// selected function drives each output
always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
        o_relay_contact_set <= 1'h0;
        o_output2           <= 1'h0;
    end else if (i_ce) begin
        o_relay_contact_set <= mf_out(relay_sel_ff, warn_ff, stalled);
        o_output2           <= mf_out(out2_sel_ff, warn_ff, stalled);
    end
end

// ****************************************************************
// read port
// ****************************************************************
reg  [31:0]      rd_mux;
integer          m;

// read values; unmapped and missing inputs read zero
always @* begin
    rd_mux = 32'h0;
    case (i_addr)
        `MPS_A_CTRL:      rd_mux = {25'h0, stall_sel_ff, 1'h0, restart_en_ff,
                                    phase_en_ff, trip_en_ff};
        `MPS_A_WARN_LVL:  rd_mux = {24'h0, warn_lvl_ff};
        `MPS_A_WARN_TIME: rd_mux = {22'h0, warn_time_ff};
        `MPS_A_TRIP_LVL:  rd_mux = {24'h0, trip_lvl_ff};
        `MPS_A_TRIP_TIME: rd_mux = {22'h0, trip_time_ff};
        `MPS_A_STALL_LVL: rd_mux = {24'h0, stall_lvl_ff};
        `MPS_A_RATED:     rd_mux = {16'h0, rated_ff};
        `MPS_A_OUT_SEL:   rd_mux = {19'h0, out2_sel_ff, 3'h0, relay_sel_ff};
        `MPS_A_STATUS:    rd_mux = {11'h0, in_closed, 8'h0, stalled, warn_ff,
                                    o_out_block, extb_trip_ff, exta_trip_ff,
                                    phase_trip_ff, ol_trip_ff, 1'h0};
        default: begin
            for (m = 0; m < 5; m = m + 1) begin
                if (i_addr == `MPS_A_IN_SEL0 + 8'h04 * m[7:0]
                    && (m < 3 || EXT_IO != 0))
                    rd_mux = {27'h0, in_sel_ff[m]};
            end
        end
    endcase
end

// data stand only in the cycle after the read strobe
always @(posedge i_core_clk) begin
    if (!i_rst_n)
        o_rdata <= 32'h0;
    else if (i_ce)
        o_rdata <= i_rd ? rd_mux : 32'h0;
end

endmodule

// file: dv/mps_drive_model.sv
`timescale 1ns/100ps
// ****************************************************************
// power stage and external contacts seen by the supervisor
// ****************************************************************
module mps_drive_model (
    // clock and bench commands
    input  logic        i_core_clk,
    input  logic [15:0] i_load,
    input  logic [2:0]  i_open_cmd,
    input  logic [4:0]  i_contact_cmd,
    // pins toward the supervisor
    output logic [15:0] o_out_current,
    output logic [2:0]  o_phase_open,
    output logic [4:0]  o_multi_in_closed
);
    // idle plant: phases whole, contact on input five closed to common
    initial begin
        o_out_current     = 16'h0;
        o_phase_open      = 3'h0;
        o_multi_in_closed = 5'h10;
    end
    // current sensor updates once per clock
    always @(posedge i_core_clk) begin
        o_out_current <= i_load;
    end
    // phase wires are unsynchronised, so they move between edges
    always @(i_open_cmd) begin
        o_phase_open <= #7 i_open_cmd;
    end
    // normally open and normally closed contacts change between edges
    always @(i_contact_cmd) begin
        o_multi_in_closed <= #7 i_contact_cmd;
    end
endmodule

// file: dv/mps_supervisor_chk.sv
`timescale 1ns/100ps
// ****************************************************************
// port checker for the protection supervisor
// ****************************************************************
module mps_supervisor_chk (
    // clock and reset
    input logic        i_core_clk,
    input logic        i_rst_n,
    input logic        i_ce,
    // register port
    input logic [7:0]  i_addr,
    input logic [31:0] i_wdata,
    input logic        i_wr,
    input logic        i_rd,
    input logic [31:0] o_rdata,
    // drive state
    input logic        i_accel,
    input logic        i_steady,
    input logic        i_decel,
    input logic        i_dc_bus_limit,
    // drive commands
    input logic        o_out_block,
    input logic        o_stall_decel,
    input logic        o_decel_hold,
    input logic        o_use_cfg_ramp,
    input logic        o_restart_cnt_clr
);
    // a write of the fault reset command
    wire flt_wr = i_wr && (i_addr == 8'h34) && i_wdata[0];

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // read data only in the cycle after a read
    chk_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
        else $error("read data seen without a read");
    chk_hold_limit: assert property (
        o_decel_hold |-> $past(i_dc_bus_limit) || $past(i_dc_bus_limit, 2))
        else $error("deceleration paused without bus at limit");
    chk_hold_motion: assert property (
        o_decel_hold |-> $past(i_decel) || $past(i_decel, 2))
        else $error("deceleration paused while not decelerating");
    chk_stall_motion: assert property (
        o_stall_decel |-> $past(i_accel) || $past(i_steady) || $past(i_accel, 2)
                          || $past(i_steady, 2))
        else $error("stall deceleration outside acceleration or steady speed");
    chk_ramp_steady: assert property (
        o_use_cfg_ramp |-> $past(i_steady) || $past(i_steady, 2))
        else $error("configured ramp flagged outside steady speed");
    chk_clr_pulse: assert property (
        o_restart_cnt_clr |=> !o_restart_cnt_clr)
        else $error("restart counter clear longer than one cycle");
    chk_clr_trip: assert property (
        $rose(o_restart_cnt_clr) |-> ##[0:2] o_out_block)
        else $error("restart counter clear without output block");
    chk_block_release: assert property (
        $fell(o_out_block) |-> $past(flt_wr, 2) || $past(flt_wr, 3))
        else $error("output block dropped without fault reset");
    chk_blocked_quiet: assert property (
        o_out_block && $past(o_out_block) |-> !o_stall_decel && !o_decel_hold)
        else $error("stall action while output blocked");
endmodule

bind mps_supervisor mps_supervisor_chk i_mps_supervisor_chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_accel(i_accel),
    .i_steady(i_steady), .i_decel(i_decel), .i_dc_bus_limit(i_dc_bus_limit),
    .o_out_block(o_out_block), .o_stall_decel(o_stall_decel),
    .o_decel_hold(o_decel_hold), .o_use_cfg_ramp(o_use_cfg_ramp),
    .o_restart_cnt_clr(o_restart_cnt_clr)
);

// file: dv/tb_mps_supervisor.sv
`timescale 1ns/100ps
module tb_mps_supervisor;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic        i_core_clk     = 1'b0;
    logic        i_rst_n        = 1'b0;
    logic        i_ce           = 1'b1;
    logic [7:0]  i_addr         = 8'h00;
    logic [31:0] i_wdata        = 32'h0;
    logic        i_wr           = 1'b0;
    logic        i_rd           = 1'b0;
    logic        i_accel        = 1'b0;
    logic        i_steady       = 1'b0;
    logic        i_decel        = 1'b0;
    logic        i_dc_bus_limit = 1'b0;
    logic [15:0] load           = 16'h0;
    logic [2:0]  open_cmd       = 3'h0;
    logic [4:0]  contact_cmd    = 5'h10;
    logic        clr_seen       = 1'b0;
    int          bad_count      = 0;
    int          n_tests        = 0;
    int          cycles         = 0;
    wire  [15:0] i_out_current;
    wire  [2:0]  i_phase_open;
    wire  [4:0]  i_multi_in_closed;
    wire  [31:0] o_rdata;
    wire         o_out_block;
    wire         o_stall_decel;
    wire         o_decel_hold;
    wire         o_use_cfg_ramp;
    wire         o_restart_cnt_clr;
    wire         o_relay_contact_set;
    wire         o_output2;
    wire  [5:0]  outs = {o_output2, o_relay_contact_set, o_use_cfg_ramp, o_decel_hold,
                         o_stall_decel, o_out_block};
    logic [7:0]  reg_addr [0:14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                                     8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c};
    logic [31:0] reg_rst [0:14]  = '{32'h1, 32'h96, 32'h64, 32'hb4, 32'h258, 32'h96, 32'h100,
                                     32'h1111, 32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h0, 32'h0};

    // clock and cycle ceiling
    always #12.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (o_restart_cnt_clr === 1'b1) begin
            clr_seen <= 1'b1;
        end
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ****************************************************************
    // design and plant
    // ****************************************************************
    mps_supervisor #(.TICK_CYCLES(4)) i_mps_supervisor (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_out_current(i_out_current), .i_accel(i_accel), .i_steady(i_steady),
        .i_decel(i_decel), .i_dc_bus_limit(i_dc_bus_limit), .i_phase_open(i_phase_open),
        .i_multi_in_closed(i_multi_in_closed), .o_out_block(o_out_block),
        .o_stall_decel(o_stall_decel), .o_decel_hold(o_decel_hold),
        .o_use_cfg_ramp(o_use_cfg_ramp), .o_restart_cnt_clr(o_restart_cnt_clr),
        .o_relay_contact_set(o_relay_contact_set), .o_output2(o_output2)
    );
    mps_drive_model i_mps_drive_model (
        .i_core_clk(i_core_clk), .i_load(load), .i_open_cmd(open_cmd),
        .i_contact_cmd(contact_cmd), .o_out_current(i_out_current),
        .o_phase_open(i_phase_open), .o_multi_in_closed(i_multi_in_closed)
    );

    // ****************************************************************
    // bus and compare tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        check("read data", exp, o_rdata);
    endtask
    // wait a bounded time for one drive output to reach a level, end on an edge
    task automatic wait_out(input int idx, input logic want, input int lim);
        int k;
        k = 0;
        while (outs[idx] !== want && k < lim) begin
            @(posedge i_core_clk);
            #1;
            k++;
        end
        check("drive output", {31'h0, want}, {31'h0, outs[idx]});
        @(posedge i_core_clk);
    endtask
    // after n cycles the output must still show the level
    task automatic settle(input int idx, input logic want, input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
        check("held output", {31'h0, want}, {31'h0, outs[idx]});
        @(posedge i_core_clk);
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        wr(8'h3c, 32'hffff);
        for (int i = 0; i < 15; i++) begin
            rd(reg_addr[i], reg_rst[i]);
        end
        // warning on the relay after three ticks above 100 percent
        wr(8'h18, 32'h64);
        wr(8'h04, 32'h64);
        wr(8'h08, 32'h3);
        wr(8'h1c, 32'h0705);
        @(posedge i_core_clk);
        load <= 16'd150;
        settle(4, 1'b0, 4);
        wait_out(4, 1'b1, 40);
        load <= 16'd50;
        wait_out(4, 1'b0, 6);
        // stall prevention in each motion state
        wr(8'h14, 32'h64);
        wr(8'h00, 32'h31);
        i_accel <= 1'b1;
        load    <= 16'd150;
        wait_out(1, 1'b1, 8);
        wait_out(5, 1'b1, 8);
        i_accel  <= 1'b0;
        i_steady <= 1'b1;
        wait_out(3, 1'b1, 8);
        wait_out(1, 1'b1, 8);
        wr(8'h00, 32'h01);
        wait_out(1, 1'b0, 8);
        settle(5, 1'b1, 4);
        i_steady       <= 1'b0;
        i_decel        <= 1'b1;
        i_dc_bus_limit <= 1'b1;
        wr(8'h00, 32'h41);
        wait_out(2, 1'b1, 8);
        i_dc_bus_limit <= 1'b0;
        wait_out(2, 1'b0, 8);
        i_decel <= 1'b0;
        // overload trip with restart counter clear
        wr(8'h0c, 32'h64);
        wr(8'h10, 32'h12d);
        wr(8'h00, 32'h05);
        settle(0, 1'b0, 1000);
        wait_out(0, 1'b1, 400);
        check("restart clear", 32'h1, {31'h0, clr_seen});
        wr(8'h34, 32'h1);
        settle(0, 1'b1, 6);
        load <= 16'd50;
        repeat (2) @(posedge i_core_clk); // compare lags the load
        wr(8'h34, 32'h1);
        wait_out(0, 1'b0, 8);
        wr(8'h10, 32'h0);
        wr(8'h00, 32'h00);
        load <= 16'd150;
        settle(0, 1'b0, 20);
        load <= 16'd50;
        // open phase
        wr(8'h00, 32'h02);
        open_cmd <= 3'b010;
        wait_out(0, 1'b1, 10);
        open_cmd <= 3'b000;
        settle(0, 1'b1, 6);
        wr(8'h34, 32'h1);
        wait_out(0, 1'b0, 8);
        // normally open contact on input four
        wr(8'h2c, 32'h12);
        settle(0, 1'b0, 6);
        contact_cmd <= 5'h18;
        wait_out(0, 1'b1, 10);
        contact_cmd <= 5'h10;
        settle(0, 1'b1, 6);
        wr(8'h34, 32'h1);
        wait_out(0, 1'b0, 8);
        // normally closed contact on input five, function changed after trip
        wr(8'h2c, 32'h3);
        wr(8'h30, 32'h13);
        contact_cmd <= 5'h00;
        wait_out(0, 1'b1, 10);
        wr(8'h30, 32'h4);
        wr(8'h34, 32'h1);
        settle(0, 1'b1, 8);
        contact_cmd <= 5'h10;
        repeat (6) @(posedge i_core_clk);
        wr(8'h34, 32'h1);
        wait_out(0, 1'b0, 8);
        wrap_up();
    end
endmodule
